// *** inc/cable_reflectometry_consts.vh ***
/*
  Constants for the cable reflectometry configuration bank: register
  indices, reset values, writable masks, field positions and timing.
  Assumes inclusion by bare name from the design files.
*/
`ifndef CABLE_REFLECTOMETRY_CONSTS_VH
`define CABLE_REFLECTOMETRY_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_CFG_A        10'h180
`define IDX_SILENCE      10'h181
`define IDX_DUR_LOW      10'h182
`define IDX_DUR_HIGH     10'h183
`define IDX_SHADOW       10'h184
`define IDX_CFG_B        10'h185
`define IDX_STATE        10'h186

// Reset values
`define RST_CFG_A        16'h0752
`define RST_SILENCE      16'hc850
`define RST_DUR_LOW      16'h5326
`define RST_DUR_HIGH     16'ha01e
`define RST_SHADOW       16'he976
`define RST_CFG_B        16'h19cf

// Writable bits; reserved bits read as zero
`define MASK_CFG_A       16'h1fff
`define MASK_SILENCE     16'hfff0
`define MASK_DUR_LOW     16'h7fff
`define MASK_DUR_HIGH    16'hff3f
`define MASK_SHADOW      16'hff77
`define MASK_CFG_B       16'h39ff

// Field positions
`define F_SKIP_CD        12
`define F_CROSS_DIS      11
`define F_LINK_PULSE     10
`define F_AVG_HI         9
`define F_AVG_LO         7
`define F_SEGNUM_HI      6
`define F_SEGNUM_LO      4
`define F_CYC_HI         3
`define F_CYC_LO         0
`define F_THR_HI         15
`define F_THR_LO         8
`define F_POST_HI        7
`define F_POST_LO        6
`define F_PRE_HI         5
`define F_PRE_LO         4
`define F_SPAN_HI        13
`define F_SPAN_LO        11
`define F_PTYPE_HI       8
`define F_PTYPE_LO       4
`define F_SDW5_HI        3
`define F_SDW5_LO        0

// Average code that is reserved
`define AVG_RESERVED     3'h7

// Timing: system clocks per microsecond of cycle time, at 200 MHz
`define CLK_PER_US       12'h0c8

`endif

// *** hw/cfg_word.v ***
/*
  One 16-bit software register with byte enables, writable mask and
  reset value. Assumes writes come from a single-cycle strobe.
*/
`timescale 1ns/1ps
`default_nettype none

module cfg_word #(
  parameter [15:0] RESET = 16'h0000,
  parameter [15:0] MASK  = 16'hffff
) (
  input  wire        clk,
  input  wire        sys_rst,
  input  wire        wr_en,
  input  wire [15:0] wr_be,
  input  wire [15:0] wr_data,
  output reg  [15:0] q
);

  wire [15:0] merged;

  // Unselected lanes keep their old contents
  assign merged = (q & ~wr_be) | (wr_data & wr_be);

  // Reserved bits can never become set
  always @(posedge clk) begin
    if (sys_rst) begin
      q <= RESET & MASK;
    end else if (wr_en) begin
      q <= merged & MASK;
    end
  end

endmodule

`default_nettype wire

// *** hw/cfg_decode.v ***
/*
  Combinational decode of configuration codes into the forms the test
  engine consumes. Assumes its outputs are registered by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cable_reflectometry_consts.vh"

module cfg_decode (
  input  wire [2:0]  avg_code,
  input  wire [2:0]  seg_count,
  input  wire [3:0]  cycle_time,
  input  wire        skip_cd,
  output wire [6:0]  avg_cycles,
  output wire        avg_reserved,
  output wire [4:0]  seg_active,
  output wire [11:0] cycle_clks,
  output wire [3:0]  chan_en
);

  localparam [11:0] CLKS_PER_US = `CLK_PER_US;

  genvar g;

  // Reserved code falls back to the longest average
  assign avg_reserved = (avg_code == `AVG_RESERVED);
  assign avg_cycles   = avg_reserved ? 7'h40 : (7'h01 << avg_code);

  // Microseconds to system clocks, at most 3000
  assign cycle_clks = {8'h00, cycle_time} * CLKS_PER_US;

  // Pairs C and D dropped when skipping
  assign chan_en = skip_cd ? 4'h3 : 4'hf;

  // Only the first seg_count segments run; counts above five run all
  generate
    for (g = 0; g < 5; g = g + 1) begin : seg
      localparam [2:0] IDX = g;
      assign seg_active[g] = (seg_count > IDX);
    end
  endgenerate

endmodule

`default_nettype wire

// *** hw/cable_reflectometry_config.v ***
/*
  Configuration bank of the cable reflectometry test engine: six
  16-bit registers and one state word on APB, plus a snapshot of every
  field that the engine uses while a test runs.
  Assumes test_start and test_done come from engine logic on clk.
*/
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "cable_reflectometry_consts.vh"

module cable_reflectometry_config #(
  parameter ADDR_W = 12
) (
  input  wire              clk,
  input  wire              sys_rst,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [ADDR_W-1:0] paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output wire              pready,
  output reg  [31:0]       prdata,
  output wire              pslverr,
  input  wire              test_start,
  input  wire              test_done,
  output reg               test_busy,
  output reg  [3:0]        channel_enable,
  output reg               cross_listen_disable,
  output reg               link_pulse_check,
  output reg  [2:0]        average_count,
  output reg  [6:0]        average_cycles,
  output reg  [2:0]        segment_count,
  output reg  [4:0]        segment_active,
  output reg  [3:0]        cycle_time,
  output reg  [11:0]       cycle_clks,
  output reg  [7:0]        energy_threshold,
  output reg  [1:0]        pre_quiet_window,
  output reg  [1:0]        post_quiet_window,
  output reg  [4:0]        segment1_length,
  output reg  [4:0]        segment2_length,
  output reg  [4:0]        segment3_length,
  output reg  [5:0]        segment4_length,
  output reg  [7:0]        segment5_length,
  output reg  [2:0]        segment1_peak_wait,
  output reg  [2:0]        segment2_peak_wait,
  output reg  [3:0]        segment3_peak_wait,
  output reg  [3:0]        segment4_peak_wait,
  output reg  [3:0]        segment5_peak_wait,
  output reg  [2:0]        average_peak_span,
  output reg  [4:0]        segment_pulse_type
);

  // Reset images of the six registers; the snapshot resets from these
  // so that reset outputs never drift from the register reset values
  localparam [15:0] RST_A   = `RST_CFG_A;
  localparam [15:0] RST_SIL = `RST_SILENCE;
  localparam [15:0] RST_DLO = `RST_DUR_LOW;
  localparam [15:0] RST_DHI = `RST_DUR_HIGH;
  localparam [15:0] RST_SDW = `RST_SHADOW;
  localparam [15:0] RST_B   = `RST_CFG_B;

  // Live register contents
  wire [15:0] cfg_a;
  wire [15:0] silence;
  wire [15:0] dur_low;
  wire [15:0] dur_high;
  wire [15:0] shadow;
  wire [15:0] cfg_b;

  // Decoded views of the live configuration
  wire [6:0]  dec_avg_cycles;
  wire        dec_avg_reserved;
  wire [4:0]  dec_seg_active;
  wire [11:0] dec_cycle_clks;
  wire [3:0]  dec_chan_en;

  // Decoded views of the reset image
  wire [6:0]  rst_avg_cycles;
  wire [4:0]  rst_seg_active;
  wire [11:0] rst_cycle_clks;
  wire [3:0]  rst_chan_en;

  // Bus decode
  wire [ADDR_W-3:0] word_idx;
  wire              aligned;
  wire              setup;
  wire              wr_access;
  wire [15:0]       wr_be;
  wire              hit_a;
  wire              hit_silence;
  wire              hit_dur_low;
  wire              hit_dur_high;
  wire              hit_shadow;
  wire              hit_b;
  wire              hit_state;
  wire              mapped;
  wire [15:0]       state_word;
  wire              snap;

  reg  [15:0]       rd_mux;
  reg               err_r;

  // Word index and alignment of the byte address
  assign word_idx = paddr[ADDR_W-1:2];
  assign aligned  = (paddr[1:0] == 2'h0);

  // Register selects; misaligned addresses map to nothing
  assign hit_a        = aligned && (word_idx == `IDX_CFG_A);
  assign hit_silence  = aligned && (word_idx == `IDX_SILENCE);
  assign hit_dur_low  = aligned && (word_idx == `IDX_DUR_LOW);
  assign hit_dur_high = aligned && (word_idx == `IDX_DUR_HIGH);
  assign hit_shadow   = aligned && (word_idx == `IDX_SHADOW);
  assign hit_b        = aligned && (word_idx == `IDX_CFG_B);
  assign hit_state    = aligned && (word_idx == `IDX_STATE);
  assign mapped       = hit_a | hit_silence | hit_dur_low | hit_dur_high |
                        hit_shadow | hit_b | hit_state;

  // Zero wait states: access phase always completes at once
  assign setup     = psel && !penable;
  assign pready    = 1'b1;
  assign pslverr   = psel && penable && err_r;
  assign wr_access = psel && penable && pwrite && !err_r;

  // Only the two low byte lanes hold register bits
  assign wr_be = {{8{pstrb[1]}}, {8{pstrb[0]}}};

  // Configuration registers
  cfg_word #(
    .RESET (`RST_CFG_A),
    .MASK  (`MASK_CFG_A)
  ) u_cfg_a (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_access && hit_a),
    .wr_be   (wr_be),
    .wr_data (pwdata[15:0]),
    .q       (cfg_a)
  );

  cfg_word #(
    .RESET (`RST_SILENCE),
    .MASK  (`MASK_SILENCE)
  ) u_silence (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_access && hit_silence),
    .wr_be   (wr_be),
    .wr_data (pwdata[15:0]),
    .q       (silence)
  );

  cfg_word #(
    .RESET (`RST_DUR_LOW),
    .MASK  (`MASK_DUR_LOW)
  ) u_dur_low (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_access && hit_dur_low),
    .wr_be   (wr_be),
    .wr_data (pwdata[15:0]),
    .q       (dur_low)
  );

  cfg_word #(
    .RESET (`RST_DUR_HIGH),
    .MASK  (`MASK_DUR_HIGH)
  ) u_dur_high (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_access && hit_dur_high),
    .wr_be   (wr_be),
    .wr_data (pwdata[15:0]),
    .q       (dur_high)
  );

  cfg_word #(
    .RESET (`RST_SHADOW),
    .MASK  (`MASK_SHADOW)
  ) u_shadow (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_access && hit_shadow),
    .wr_be   (wr_be),
    .wr_data (pwdata[15:0]),
    .q       (shadow)
  );

  cfg_word #(
    .RESET (`RST_CFG_B),
    .MASK  (`MASK_CFG_B)
  ) u_cfg_b (
    .clk     (clk),
    .sys_rst (sys_rst),
    .wr_en   (wr_access && hit_b),
    .wr_be   (wr_be),
    .wr_data (pwdata[15:0]),
    .q       (cfg_b)
  );

  // Decode of the live fields, captured together with the snapshot
  cfg_decode u_decode (
    .avg_code     (cfg_a[`F_AVG_HI:`F_AVG_LO]),
    .seg_count    (cfg_a[`F_SEGNUM_HI:`F_SEGNUM_LO]),
    .cycle_time   (cfg_a[`F_CYC_HI:`F_CYC_LO]),
    .skip_cd      (cfg_a[`F_SKIP_CD]),
    .avg_cycles   (dec_avg_cycles),
    .avg_reserved (dec_avg_reserved),
    .seg_active   (dec_seg_active),
    .cycle_clks   (dec_cycle_clks),
    .chan_en      (dec_chan_en)
  );

  // Same decode on the reset image; constant inputs, folds away
  // Costs nothing in gates and keeps one decode for both paths
  cfg_decode u_rst_decode (
    .avg_code     (RST_A[`F_AVG_HI:`F_AVG_LO]),
    .seg_count    (RST_A[`F_SEGNUM_HI:`F_SEGNUM_LO]),
    .cycle_time   (RST_A[`F_CYC_HI:`F_CYC_LO]),
    .skip_cd      (RST_A[`F_SKIP_CD]),
    .avg_cycles   (rst_avg_cycles),
    .avg_reserved (),
    .seg_active   (rst_seg_active),
    .cycle_clks   (rst_cycle_clks),
    .chan_en      (rst_chan_en)
  );

  // Read-only state word: busy and reserved average code
  assign state_word = {14'h0000, dec_avg_reserved, test_busy};

  // Read multiplexer; unmapped reads return zero
  always @* begin
    rd_mux = 16'h0000;
    case (1'b1)
      hit_a:        rd_mux = cfg_a;
      hit_silence:  rd_mux = silence;
      hit_dur_low:  rd_mux = dur_low;
      hit_dur_high: rd_mux = dur_high;
      hit_shadow:   rd_mux = shadow;
      hit_b:        rd_mux = cfg_b;
      hit_state:    rd_mux = state_word;
      default:      rd_mux = 16'h0000;
    endcase
  end

  // Read data and error captured in setup so they stand registered
  // through the access phase; writes to the state word are dropped
  always @(posedge clk) begin
    if (sys_rst) begin
      prdata <= 32'h0000_0000;
      err_r  <= 1'b0;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : {16'h0000, rd_mux};
      err_r  <= !mapped;
    end
  end

  // A start while busy is ignored, so a running test keeps its set
  assign snap = test_start && !test_busy;

  // Busy: a start in the done cycle is refused, so busy still clears
  // A done with a refused start leaves the engine idle
  always @(posedge clk) begin
    if (sys_rst) begin
      test_busy <= 1'b0;
    end else if (snap) begin
      test_busy <= 1'b1;
    end else if (test_done) begin
      test_busy <= 1'b0;
    end
  end

  // Snapshot of every field at test start; values stand till next start
  // Reset state equals a start taken on the reset image
  always @(posedge clk) begin
    if (sys_rst) begin
      channel_enable       <= rst_chan_en;
      cross_listen_disable <= RST_A[`F_CROSS_DIS];
      link_pulse_check     <= RST_A[`F_LINK_PULSE];
      average_count        <= RST_A[`F_AVG_HI:`F_AVG_LO];
      average_cycles       <= rst_avg_cycles;
      segment_count        <= RST_A[`F_SEGNUM_HI:`F_SEGNUM_LO];
      segment_active       <= rst_seg_active;
      cycle_time           <= RST_A[`F_CYC_HI:`F_CYC_LO];
      cycle_clks           <= rst_cycle_clks;
      energy_threshold     <= RST_SIL[`F_THR_HI:`F_THR_LO];
      pre_quiet_window     <= RST_SIL[`F_PRE_HI:`F_PRE_LO];
      post_quiet_window    <= RST_SIL[`F_POST_HI:`F_POST_LO];
      segment1_length      <= RST_DLO[4:0];
      segment2_length      <= RST_DLO[9:5];
      segment3_length      <= RST_DLO[14:10];
      segment4_length      <= RST_DHI[5:0];
      segment5_length      <= RST_DHI[15:8];
      segment1_peak_wait   <= RST_SDW[2:0];
      segment2_peak_wait   <= RST_SDW[6:4];
      segment3_peak_wait   <= RST_SDW[11:8];
      segment4_peak_wait   <= RST_SDW[15:12];
      segment5_peak_wait   <= RST_B[`F_SDW5_HI:`F_SDW5_LO];
      average_peak_span    <= RST_B[`F_SPAN_HI:`F_SPAN_LO];
      segment_pulse_type   <= RST_B[`F_PTYPE_HI:`F_PTYPE_LO];
    end else if (snap) begin
      channel_enable       <= dec_chan_en;
      cross_listen_disable <= cfg_a[`F_CROSS_DIS];
      link_pulse_check     <= cfg_a[`F_LINK_PULSE];
      average_count        <= cfg_a[`F_AVG_HI:`F_AVG_LO];
      average_cycles       <= dec_avg_cycles;
      segment_count        <= cfg_a[`F_SEGNUM_HI:`F_SEGNUM_LO];
      segment_active       <= dec_seg_active;
      cycle_time           <= cfg_a[`F_CYC_HI:`F_CYC_LO];
      cycle_clks           <= dec_cycle_clks;
      energy_threshold     <= silence[`F_THR_HI:`F_THR_LO];
      pre_quiet_window     <= silence[`F_PRE_HI:`F_PRE_LO];
      post_quiet_window    <= silence[`F_POST_HI:`F_POST_LO];
      segment1_length      <= dur_low[4:0];
      segment2_length      <= dur_low[9:5];
      segment3_length      <= dur_low[14:10];
      segment4_length      <= dur_high[5:0];
      segment5_length      <= dur_high[15:8];
      segment1_peak_wait   <= shadow[2:0];
      segment2_peak_wait   <= shadow[6:4];
      segment3_peak_wait   <= shadow[11:8];
      segment4_peak_wait   <= shadow[15:12];
      segment5_peak_wait   <= cfg_b[`F_SDW5_HI:`F_SDW5_LO];
      average_peak_span    <= cfg_b[`F_SPAN_HI:`F_SPAN_LO];
      segment_pulse_type   <= cfg_b[`F_PTYPE_HI:`F_PTYPE_LO];
    end
  end

endmodule

`default_nettype wire

// *** dv/refl_cfg_checker.sv ***
/*
  Checker for the reflectometry configuration bank: engine handshake,
  snapshot hold, decode relations and APB answer timing.
  Assumes one clock domain and binding to the top module's ports.
*/
`timescale 1ns/1ps
`default_nettype none
module refl_cfg_checker (
  input wire logic        clk,
  input wire logic        sys_rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        test_start,
  input wire logic        test_done,
  input wire logic        test_busy,
  input wire logic [3:0]  channel_enable,
  input wire logic [2:0]  average_count,
  input wire logic [6:0]  average_cycles,
  input wire logic [2:0]  segment_count,
  input wire logic [4:0]  segment_active,
  input wire logic [3:0]  cycle_time,
  input wire logic [11:0] cycle_clks,
  input wire logic [7:0]  energy_threshold,
  input wire logic [4:0]  segment_pulse_type
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // Start is only taken while idle
  sequence s_accept; test_start && !test_busy; endsequence
  sequence s_access; psel && !penable ##1 psel && penable; endsequence
  property p_accept; s_accept |=> test_busy; endproperty
  a_accept: assert property (p_accept) else $error("start not taken");
  // Snapshot must not move without an accepted start
  property p_hold;
    !(test_start && !test_busy) |=> $stable({channel_enable, average_count, segment_count,
      cycle_time, energy_threshold, segment_pulse_type});
  endproperty
  a_hold: assert property (p_hold) else $error("snapshot moved");
  property p_busy_hold; test_busy && !test_done |=> test_busy; endproperty
  a_busy_hold: assert property (p_busy_hold) else $error("busy dropped");
  property p_done; test_busy && test_done |=> !test_busy; endproperty
  a_done: assert property (p_done) else $error("busy not cleared");
  property p_chan; channel_enable == 4'h3 || channel_enable == 4'hf; endproperty
  a_chan: assert property (p_chan) else $error("bad channel set");
  property p_avg;
    average_cycles == ((average_count == 3'h7) ? 7'h40 : 7'h01 << average_count);
  endproperty
  a_avg: assert property (p_avg) else $error("bad average decode");
  property p_seg;
    segment_active == {segment_count > 3'd4, segment_count > 3'd3, segment_count > 3'd2,
      segment_count > 3'd1, segment_count > 3'd0};
  endproperty
  a_seg: assert property (p_seg) else $error("bad segment decode");
  property p_cyc; cycle_clks == cycle_time * 12'd200; endproperty
  a_cyc: assert property (p_cyc) else $error("bad cycle length");
  // Zero wait states, so the access phase answers at once
  property p_ready; s_access |-> pready; endproperty
  a_ready: assert property (p_ready) else $error("no ready in access");
  property p_err; pslverr |-> psel && penable; endproperty
  a_err: assert property (p_err) else $error("error outside access");
endmodule
bind cable_reflectometry_config refl_cfg_checker u_chk (.clk, .sys_rst, .psel, .penable,
  .pready, .pslverr, .test_start, .test_done, .test_busy, .channel_enable, .average_count,
  .average_cycles, .segment_count, .segment_active, .cycle_time, .cycle_clks,
  .energy_threshold, .segment_pulse_type);
`default_nettype wire

// *** dv/cable_reflectometry_config_tb_top.sv ***
/*
  Self-checking bench for the reflectometry configuration bank.
  Assumes APB with zero wait states and engine pulses on clk.
*/
`timescale 1ns/1ps
`default_nettype none
`include "cable_reflectometry_consts.vh"
module cable_reflectometry_config_tb_top;
  // Byte addresses are four times the register index
  localparam logic [11:0] CFG_BASE   = {`IDX_CFG_A, 2'b00};
  localparam logic [11:0] STATE_ADDR = {`IDX_STATE, 2'b00};
  logic        clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, err;
  logic        test_start = 0, test_done = 0;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, rd;
  logic [3:0]  pstrb = 0;
  logic [15:0] v;
  wire         pready, pslverr, test_busy, cross_listen_disable, link_pulse_check;
  wire [1:0]   pre_quiet_window, post_quiet_window;
  wire [2:0]   average_count, segment_count, segment1_peak_wait, segment2_peak_wait;
  wire [2:0]   average_peak_span;
  wire [3:0]   channel_enable, cycle_time, segment3_peak_wait, segment4_peak_wait;
  wire [3:0]   segment5_peak_wait;
  wire [4:0]   segment_active, segment1_length, segment2_length, segment3_length;
  wire [4:0]   segment_pulse_type;
  wire [5:0]   segment4_length;
  wire [6:0]   average_cycles;
  wire [7:0]   energy_threshold, segment5_length;
  wire [11:0]  cycle_clks;
  wire [31:0]  prdata;
  int          miscompares = 0, check_count = 0;
  logic [15:0] rv [6] = '{16'h0752, 16'hc850, 16'h5326, 16'ha01e, 16'he976, 16'h19cf};
  logic [15:0] wv [6] = '{16'h0000, 16'h5aff, 16'hd2b5, 16'h3bc9, 16'h12bc, 16'hd6aa};
  logic [15:0] mk [6] = '{16'h1fff, 16'hfff0, 16'h7fff, 16'hff3f, 16'hff77, 16'h39ff};

  cable_reflectometry_config DUT (.clk, .sys_rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb, .pready, .prdata, .pslverr, .test_start, .test_done, .test_busy, .channel_enable,
    .cross_listen_disable, .link_pulse_check, .average_count, .average_cycles, .segment_count,
    .segment_active, .cycle_time, .cycle_clks, .energy_threshold, .pre_quiet_window,
    .post_quiet_window, .segment1_length, .segment2_length, .segment3_length,
    .segment4_length, .segment5_length, .segment1_peak_wait, .segment2_peak_wait,
    .segment3_peak_wait, .segment4_peak_wait, .segment5_peak_wait, .average_peak_span,
    .segment_pulse_type);

  // 200 MHz clock
  always #2.5 clk = ~clk;

  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One APB transfer; waits on pready, not on an assumed latency
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d);
    @(posedge clk);
    psel <= 1;
    penable <= 0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    pstrb <= 4'hf;
    @(posedge clk);
    penable <= 1;
    // Only the watchdog ends a wait that never gets an answer
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 0;
    penable <= 0;
  endtask

  // One-cycle start or done pulse, then look once outputs settle
  task automatic pulse(input logic s);
    @(posedge clk);
    if (s) test_start <= 1;
    else test_done <= 1;
    @(posedge clk);
    test_start <= 0;
    test_done <= 0;
    @(negedge clk);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    sys_rst <= 0;
    for (int i = 0; i < 6; i++) begin
      apb(CFG_BASE + 4 * i, 0, 0);
      chk("reset value", rd, {16'h0, rv[i]});
    end
    chk("chan", channel_enable, 4'hf);
    chk("nlp", link_pulse_check, 1);
    chk("avg", average_cycles, 7'h40);
    chk("segs", segment_active, 5'h1f);
    chk("cyc", cycle_clks, 12'h190);
    chk("thr", energy_threshold, 8'hc8);
    chk("len1", segment1_length, 5'h06);
    chk("wait5", segment5_peak_wait, 4'hf);
    chk("span", average_peak_span, 3'h3);
    chk("ptype", segment_pulse_type, 5'h1c);
    // Average codes 0 to 6, with reserved bits set on the write
    for (int i = 0; i < 7; i++) begin
      v = 16'he000 | (i[0] << 12) | (i[1] << 11) | (!i[0] << 10) | (i << 7) | (i << 4) | (i + 1);
      apb(CFG_BASE, 1, {16'h0, v});
      apb(CFG_BASE, 0, 0);
      chk("cfg rb", rd, {19'h0, v[12:0]});
      pulse(1);
      chk("busy", test_busy, 1);
      chk("chan", channel_enable, i[0] ? 4'h3 : 4'hf);
      chk("xlisten", cross_listen_disable, i[1]);
      chk("nlp", link_pulse_check, !i[0]);
      chk("avg", average_cycles, 1 << i);
      chk("segs", segment_active, i > 5 ? 5'h1f : (1 << i) - 1);
      chk("cyc", cycle_clks, (i + 1) * 200);
      pulse(0);
      chk("idle", test_busy, 0);
    end
    // Writes and a second start during a test must not reach the outputs
    pulse(1);
    apb(CFG_BASE, 1, 32'h0000_1000);
    pulse(1);
    chk("held chan", channel_enable, 4'hf);
    chk("held cyc", cycle_clks, 12'd1400);
    pulse(0);
    pulse(1);
    chk("new chan", channel_enable, 4'h3);
    chk("new cyc", cycle_clks, 0);
    pulse(0);
    for (int i = 1; i < 6; i++) begin
      apb(CFG_BASE + 4 * i, 1, {16'hffff, wv[i]});
      apb(CFG_BASE + 4 * i, 0, 0);
      chk("rw", rd, {16'h0, wv[i] & mk[i]});
    end
    pulse(1);
    v = wv[1];
    chk("thr", energy_threshold, v[15:8]);
    chk("pre", pre_quiet_window, v[5:4]);
    chk("post", post_quiet_window, v[7:6]);
    v = wv[2];
    chk("len1", segment1_length, v[4:0]);
    chk("len2", segment2_length, v[9:5]);
    chk("len3", segment3_length, v[14:10]);
    v = wv[3];
    chk("len4", segment4_length, v[5:0]);
    chk("len5", segment5_length, v[15:8]);
    v = wv[4];
    chk("w1", segment1_peak_wait, v[2:0]);
    chk("w2", segment2_peak_wait, v[6:4]);
    chk("w3", segment3_peak_wait, v[11:8]);
    chk("w4", segment4_peak_wait, v[15:12]);
    v = wv[5];
    chk("w5", segment5_peak_wait, v[3:0]);
    chk("span", average_peak_span, v[13:11]);
    chk("ptype", segment_pulse_type, v[8:4]);
    pulse(0);
    // Unmapped and misaligned places answer with an error
    apb(CFG_BASE + 12'h01c, 1, 32'h0000_ffff);
    chk("err w", err, 1);
    apb(CFG_BASE + 12'h002, 0, 0);
    chk("err r", err, 1);
    chk("err data", rd, 0);
    // Reserved average code: flagged in the state word, runs as 64 cycles
    apb(CFG_BASE, 1, 32'h0000_07d2);
    apb(STATE_ADDR, 0, 0);
    chk("state idle", rd, 32'h0000_0002);
    pulse(1);
    chk("avg rsv", average_cycles, 7'h40);
    chk("avg code", average_count, 3'h7);
    apb(STATE_ADDR, 0, 0);
    chk("state busy", rd, 32'h0000_0003);
    pulse(0);
    tally_and_finish;
  end

  // Watchdog well beyond the expected run length
  initial begin
    #50000;
    miscompares++;
    tally_and_finish;
  end
endmodule
`default_nettype wire
